/* hdl/ioexp_pkg.sv */
// Shared constants for the serial I/O expander
package ioexp_pkg;
    localparam int          PORT_W       = 8;
    localparam logic [3:0]  ADDR_FIXED   = 4'h4;
    localparam logic [1:0]  CMD_INPUT    = 2'h0;
    localparam logic [1:0]  CMD_OUTPUT   = 2'h1;
    localparam logic [1:0]  CMD_POLARITY = 2'h2;
    localparam logic [1:0]  CMD_CONFIG   = 2'h3;
    localparam logic [7:0]  OUT_RESET    = 8'hFF;
    localparam logic [7:0]  POL_RESET    = 8'h00;
    localparam logic [7:0]  CFG_RESET    = 8'hFF;
    localparam logic [2:0]  BIT_LAST     = 3'h7;
    localparam int          CLK_MHZ      = 250;
    localparam int          FAST_KHZ     = 400;
    localparam int          SCL_PERIOD_CYC = (CLK_MHZ * 1000) / FAST_KHZ;
    typedef enum logic [2:0] {
        IOEXP_IDLE,
        IOEXP_ADDR,
        IOEXP_ADDR_ACK,
        IOEXP_WR_BYTE,
        IOEXP_WR_ACK,
        IOEXP_RD_BYTE,
        IOEXP_RD_ACK,
        IOEXP_SKIP
    } ioexp_state_e;
endpackage

/* hdl/ioexp_top.sv */
// Eight-bit I/O expander behind a two-wire serial slave
`timescale 1ns/1ps
module ioexp_top
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    input  wire logic       addr_strap_bit0,
    input  wire logic       addr_strap_bit1,
    input  wire logic       addr_strap_bit2,
    input  wire logic [7:0] port_pin_in,
    output logic      [7:0] port_pin_out,
    output logic      [7:0] port_pin_oe_n,
    output logic      [7:0] port_pullup_en,
    output logic            alert_out,
    output logic            alert_oe_n
);
    // Three-stage input sampling
    logic [2:0]  scl_s_q;
    logic [2:0]  sda_s_q;
    logic [7:0]  pin_s1_q;
    logic [7:0]  pin_s2_q;
    logic [7:0]  pin_s3_q;
    logic        scl_q;
    logic        sda_q;
    logic [7:0]  pin_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            scl_s_q  <= 3'h7;
            sda_s_q  <= 3'h7;
            pin_s1_q <= 8'hFF;
            pin_s2_q <= 8'hFF;
            pin_s3_q <= 8'hFF;
        end
        else
        begin
            scl_s_q  <= {scl_s_q[1:0], scl_in};
            sda_s_q  <= {sda_s_q[1:0], sda_in};
            pin_s1_q <= port_pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // Filtered levels change only when stages two and three agree
    wire scl_agree = (scl_s_q[1] == scl_s_q[2]);
    wire sda_agree = (sda_s_q[1] == sda_s_q[2]);
    wire [7:0] pin_agree = ~(pin_s2_q ^ pin_s3_q);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            pin_q <= 8'hFF;
        end
        else
        begin
            if (scl_agree)
                scl_q <= scl_s_q[2];
            if (sda_agree)
                sda_q <= sda_s_q[2];
            pin_q <= (pin_agree & pin_s3_q) | (~pin_agree & pin_q);
        end
    end

    // Bus events from the filtered levels
    logic scl_prev_q;
    logic sda_prev_q;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end
        else
        begin
            scl_prev_q <= scl_q;
            sda_prev_q <= sda_q;
        end
    end
    // Edge sampling at 250 MHz resolves fast-mode bit times easily
    wire scl_rise  = scl_q & ~scl_prev_q;
    wire scl_fall  = ~scl_q & scl_prev_q;
    wire bus_start = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
    wire bus_stop  = scl_q & scl_prev_q & ~sda_prev_q & sda_q;

    // Registers
    logic [7:0]  out_q;
    logic [7:0]  pol_q;
    logic [7:0]  cfg_q;
    logic [7:0]  in_q;
    logic [1:0]  cmd_q;
    ioexp_pkg::ioexp_state_e state_q;
    logic [2:0]  bit_q;
    logic [7:0]  shift_q;
    logic        rw_q;
    logic        cmd_seen_q;
    logic        sda_drv_q;

    wire [6:0] own_addr = {ioexp_pkg::ADDR_FIXED, addr_strap_bit2,
                           addr_strap_bit1, addr_strap_bit0};
    wire [7:0] in_view  = pin_q ^ pol_q;
    wire [7:0] shift_in = {shift_q[6:0], sda_q};
    wire       addr_hit = (shift_in[7:1] == own_addr);
    wire       byte_end = scl_rise & (bit_q == ioexp_pkg::BIT_LAST);

    // Register read mux
    logic [7:0] rd_data;
    always_comb
    begin
        case (cmd_q)
            ioexp_pkg::CMD_INPUT:    rd_data = in_view;
            ioexp_pkg::CMD_OUTPUT:   rd_data = out_q;
            ioexp_pkg::CMD_POLARITY: rd_data = pol_q;
            ioexp_pkg::CMD_CONFIG:   rd_data = cfg_q;
            default:                 rd_data = in_view;
        endcase
    end

    // Input register captured at the start of each read byte while the input register is selected
    wire rd_load = (state_q == ioexp_pkg::IOEXP_ADDR_ACK || state_q == ioexp_pkg::IOEXP_RD_ACK)
                   && scl_fall && rw_q;
    wire wr_ok   = (state_q == ioexp_pkg::IOEXP_WR_BYTE) && byte_end && cmd_seen_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q    <= ioexp_pkg::IOEXP_IDLE;
            bit_q      <= 3'h0;
            shift_q    <= 8'h00;
            rw_q       <= 1'b0;
            cmd_q      <= ioexp_pkg::CMD_INPUT;
            cmd_seen_q <= 1'b0;
            sda_drv_q  <= 1'b0;
        end
        else if (bus_start)
        begin
            state_q <= ioexp_pkg::IOEXP_ADDR;
            bit_q   <= 3'h0;
            sda_drv_q <= 1'b0;
        end
        else if (bus_stop)
        begin
            state_q   <= ioexp_pkg::IOEXP_IDLE;
            sda_drv_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ioexp_pkg::IOEXP_ADDR:
                    if (scl_rise)
                    begin
                        shift_q <= shift_in;
                        bit_q   <= bit_q + 3'h1;
                        if (byte_end)
                        begin
                            rw_q <= shift_in[0];
                            state_q <= addr_hit ? ioexp_pkg::IOEXP_ADDR_ACK
                                                : ioexp_pkg::IOEXP_SKIP;
                        end
                    end
                ioexp_pkg::IOEXP_ADDR_ACK:
                    if (scl_fall)
                    begin
                        if (sda_drv_q)
                        begin
                            cmd_seen_q <= 1'b0;
                            bit_q <= 3'h0;
                            if (rw_q)
                            begin
                                state_q   <= ioexp_pkg::IOEXP_RD_BYTE;
                                shift_q   <= rd_data;
                                sda_drv_q <= ~rd_data[7];
                            end
                            else
                            begin
                                state_q   <= ioexp_pkg::IOEXP_WR_BYTE;
                                sda_drv_q <= 1'b0;
                            end
                        end
                        else
                            sda_drv_q <= 1'b1;
                    end
                ioexp_pkg::IOEXP_WR_BYTE:
                    if (scl_rise)
                    begin
                        shift_q <= shift_in;
                        bit_q   <= bit_q + 3'h1;
                        if (byte_end)
                        begin
                            state_q <= ioexp_pkg::IOEXP_WR_ACK;
                            if (!cmd_seen_q)
                            begin
                                cmd_q      <= shift_in[1:0];
                                cmd_seen_q <= 1'b1;
                            end
                        end
                    end
                ioexp_pkg::IOEXP_WR_ACK:
                    if (scl_fall)
                    begin
                        if (sda_drv_q)
                        begin
                            sda_drv_q <= 1'b0;
                            bit_q     <= 3'h0;
                            state_q   <= ioexp_pkg::IOEXP_WR_BYTE;
                        end
                        else
                            sda_drv_q <= 1'b1;
                    end
                ioexp_pkg::IOEXP_RD_BYTE:
                    if (scl_fall)
                    begin
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == ioexp_pkg::BIT_LAST)
                        begin
                            sda_drv_q <= 1'b0;
                            state_q   <= ioexp_pkg::IOEXP_RD_ACK;
                        end
                        else
                        begin
                            shift_q   <= {shift_q[6:0], 1'b0};
                            sda_drv_q <= ~shift_q[6];
                        end
                    end
                ioexp_pkg::IOEXP_RD_ACK:
                    // Master acknowledge asks for the next byte at the clock fall
                    if (scl_rise && sda_q)
                        state_q <= ioexp_pkg::IOEXP_SKIP;
                    else if (scl_fall)
                    begin
                        bit_q     <= 3'h0;
                        state_q   <= ioexp_pkg::IOEXP_RD_BYTE;
                        shift_q   <= rd_data;
                        sda_drv_q <= ~rd_data[7];
                    end
                ioexp_pkg::IOEXP_SKIP:
                    sda_drv_q <= 1'b0;
                default:
                    state_q <= ioexp_pkg::IOEXP_IDLE;
            endcase
        end
    end

    // Writable registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            out_q <= ioexp_pkg::OUT_RESET;
            pol_q <= ioexp_pkg::POL_RESET;
            cfg_q <= ioexp_pkg::CFG_RESET;
        end
        else if (wr_ok)
        begin
            case (cmd_q)
                ioexp_pkg::CMD_OUTPUT:   out_q <= shift_in;
                ioexp_pkg::CMD_POLARITY: pol_q <= shift_in;
                ioexp_pkg::CMD_CONFIG:   cfg_q <= shift_in;
                default:                 out_q <= out_q;
            endcase
        end
    end

    // Input register: refreshed on input-register reads and, while idle, when pins return to it
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            in_q <= 8'hFF;
        else if ((rd_load && cmd_q == ioexp_pkg::CMD_INPUT) || state_q == ioexp_pkg::IOEXP_IDLE
                 && pin_q == in_q)
            in_q <= pin_q;
    end

    // Alert flag
    logic alert_q;
    wire  mismatch = |(pin_q ^ in_q);
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            alert_q <= 1'b0;
        else
            alert_q <= mismatch && !(rd_load && cmd_q == ioexp_pkg::CMD_INPUT);
    end

    // Pin drive
    genvar g;
    generate
        for (g = 0; g < ioexp_pkg::PORT_W; g++)
        begin : g_pin
            assign port_pin_out[g]   = out_q[g] & ~cfg_q[g];
            assign port_pin_oe_n[g]  = cfg_q[g];
            assign port_pullup_en[g] = cfg_q[g];
        end
    endgenerate

    assign sda_out    = 1'b0;
    assign sda_oe_n   = ~sda_drv_q;
    assign alert_out  = 1'b0;
    assign alert_oe_n = ~alert_q;
endmodule // ioexp_top

/* verification/ioexp_props.sv */
// Port checks for the I/O expander, bound to its top
`timescale 1ns/1ps
module ioexp_props
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       scl_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    input wire logic [7:0] port_pin_in,
    input wire logic [7:0] port_pin_out,
    input wire logic [7:0] port_pin_oe_n,
    input wire logic [7:0] port_pullup_en,
    input wire logic       alert_out,
    input wire logic       alert_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    drive_mask_a: assert property ((port_pin_out & port_pin_oe_n) == 8'h00)
        else $error("Input pin carries a drive value");
    pullup_dir_a: assert property (port_pullup_en == port_pin_oe_n)
        else $error("Pull-up does not follow direction");
    reset_state_a: assert property ($rose(rst_n) |-> port_pin_oe_n == 8'hFF && sda_oe_n && alert_oe_n)
        else $error("Outputs not at defaults after reset");
    open_drain_a: assert property (!sda_out && !alert_out)
        else $error("Open-drain data level not low");
    sda_change_a: assert property ($changed(sda_oe_n) |-> !scl_in && !$past(scl_in, 2))
        else $error("Data line moved while clock high");
    ack_hold_a: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*8])
        else $error("Data low too short");
    port_change_a: assert property ($changed({port_pin_out, port_pin_oe_n}) |-> scl_in)
        else $error("Port outputs moved outside a write");
    alert_clear_a: assert property ($rose(alert_oe_n) |-> !scl_in ||
        $past(port_pin_in, 1) != $past(port_pin_in, 12))
        else $error("Alert released without cause");
endmodule // ioexp_props
bind ioexp_top ioexp_props u_props (.clk(clk), .rst_n(rst_n), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .port_pin_in(port_pin_in),
    .port_pin_out(port_pin_out), .port_pin_oe_n(port_pin_oe_n),
    .port_pullup_en(port_pullup_en), .alert_out(alert_out), .alert_oe_n(alert_oe_n));

/* verification/ioexp_master.sv */
// Two-wire bus master model driving the expander
`timescale 1ns/1ps
module ioexp_master
#(
    parameter int HALF = 20
)
(
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda
);
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic gap(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        gap(6);
        sda <= b;
        gap(HALF);
        scl <= 1'b1;
        gap(HALF);
        r = sda_line;
        scl <= 1'b0;
    endtask
    task automatic start();
        sda <= 1'b1;
        gap(HALF);
        scl <= 1'b1;
        gap(HALF);
        sda <= 1'b0;
        gap(HALF);
        scl <= 1'b0;
    endtask
    task automatic stop();
        gap(6);
        sda <= 1'b0;
        gap(HALF);
        scl <= 1'b1;
        gap(HALF);
        sda <= 1'b1;
        gap(HALF);
    endtask
    task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                        output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(last, ack);
    endtask
endmodule // ioexp_master

/* verification/tb_top.sv */
// Self-checking bench for the I/O expander
`timescale 1ns/1ps
module tb_top;
    logic       clk, rst_n, scl, msda, sdo, sdo_n, alo, alo_n, ack;
    logic [2:0] st;
    logic [7:0] pins, p_out, p_oe_n, p_pu, v, rg [4];
    int         fail_count = 0;
    int         total_checks = 0;
    wire        sda = msda & (sdo_n | sdo);
    ioexp_top u_dut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sdo),
        .sda_oe_n(sdo_n), .addr_strap_bit0(st[0]), .addr_strap_bit1(st[1]),
        .addr_strap_bit2(st[2]), .port_pin_in(pins), .port_pin_out(p_out),
        .port_pin_oe_n(p_oe_n), .port_pullup_en(p_pu), .alert_out(alo), .alert_oe_n(alo_n));
    ioexp_master u_mst (.clk(clk), .sda_line(sda), .scl(scl), .sda(msda));
    function automatic logic [7:0] drv(input logic [7:0] o, input logic [7:0] c);
        return o & ~c;
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [1:0] c, input logic [7:0] d,
                      output logic k);
        logic [7:0] r;
        logic       n;
        u_mst.start();
        u_mst.xfer({ioexp_pkg::ADDR_FIXED, a, 1'b0}, 1'b1, r, k);
        u_mst.xfer({6'h00, c}, 1'b1, r, n);
        u_mst.xfer(d, 1'b1, r, n);
        u_mst.stop();
    endtask
    task automatic rd(input logic [1:0] c, input logic cmd, output logic [7:0] q);
        logic n;
        if (cmd)
        begin
            u_mst.start();
            u_mst.xfer({ioexp_pkg::ADDR_FIXED, st, 1'b0}, 1'b1, q, n);
            u_mst.xfer({6'h00, c}, 1'b1, q, n);
        end
        u_mst.start();
        u_mst.xfer({ioexp_pkg::ADDR_FIXED, st, 1'b1}, 1'b1, q, n);
        u_mst.xfer(8'hFF, 1'b1, q, n);
        u_mst.stop();
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        fail_count++;
        finish_test();
    end
    initial
    begin
        rst_n = 1'b0;
        st = 3'h0;
        pins = 8'hFF;
        void'($urandom(32'hd2a4_5b04));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        chk(p_oe_n, ioexp_pkg::CFG_RESET);
        chk(p_pu, 8'hFF);
        for (int s = 0; s < 8; s++)
        begin
            st <= 3'(s);
            wr(3'(s), 2'h2, 8'h00, ack);
            chk({7'h00, ack}, 8'h00);
            wr(~3'(s), 2'h2, 8'hFF, ack);
            chk({7'h00, ack}, 8'h01);
        end
        rd(2'h2, 1'b1, v);
        chk(v, 8'h00);
        for (int n = 0; n < 2; n++)
        begin
            rg[1] = 8'($urandom);
            rg[2] = 8'($urandom);
            rg[3] = (n == 0) ? 8'h00 : 8'($urandom);
            for (int c = 3; c > 0; c--)
                wr(st, 2'(c), rg[c], ack);
            chk(p_oe_n, rg[3]);
            chk(p_out, drv(rg[1], rg[3]));
            pins <= pins ^ (8'($urandom) | 8'h01);
            repeat (12) @(posedge clk);
            chk({7'h00, alo_n}, 8'h00);
            for (int c = 1; c < 4; c++)
            begin
                rd(2'(c), 1'b1, v);
                chk(v, rg[c]);
            end
            rd(2'h0, 1'b1, v);
            chk(v, pins ^ rg[2]);
            chk({7'h00, alo_n}, 8'h01);
            rd(2'h0, 1'b0, v);
            chk(v, pins ^ rg[2]);
        end
        u_mst.start();
        u_mst.xfer({ioexp_pkg::ADDR_FIXED, st, 1'b1}, 1'b1, v, ack);
        u_mst.xfer(8'hFF, 1'b0, v, ack);
        chk(v, pins ^ rg[2]);
        u_mst.xfer(8'hFF, 1'b1, v, ack);
        chk(v, pins ^ rg[2]);
        u_mst.stop();
        u_mst.start();
        u_mst.xfer({ioexp_pkg::ADDR_FIXED, st, 1'b0}, 1'b1, v, ack);
        u_mst.xfer({6'h00, ioexp_pkg::CMD_OUTPUT}, 1'b1, v, ack);
        u_mst.xfer(8'h5A, 1'b1, v, ack);
        u_mst.xfer(8'hA5, 1'b1, v, ack);
        chk({7'h00, ack}, 8'h00);
        u_mst.stop();
        chk(p_out, drv(8'hA5, rg[3]));
        rd(2'h1, 1'b1, v);
        chk(v, 8'hA5);
        v = pins;
        pins <= ~v;
        repeat (12) @(posedge clk);
        chk({7'h00, alo_n}, 8'h00);
        pins <= v;
        repeat (12) @(posedge clk);
        chk({7'h00, alo_n}, 8'h01);
        pins <= 8'hFF;
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        rd(2'h1, 1'b1, v);
        chk(v, ioexp_pkg::OUT_RESET);
        rd(2'h3, 1'b1, v);
        chk(v, ioexp_pkg::CFG_RESET);
        finish_test();
    end
endmodule // tb_top
